// *** hw/run_clock_gate_pkg.sv ***
// Package: register map, field layout and types of the run-mode unit clock gating block
package run_clock_gate_pkg;
  localparam logic [11:0] RUN_ENABLES_OFFSET = 12'h108;
  localparam logic [11:0] SLEEP_ENABLES_OFFSET = 12'h118;
  localparam logic [11:0] DEEP_ENABLES_OFFSET = 12'h128;
  localparam logic [11:0] CLOCK_CONFIG_OFFSET = 12'h060;
  localparam logic [11:0] FAULT_STATUS_OFFSET = 12'h1f0;
  localparam int PHY_BIT = 30;
  localparam int MAC_BIT = 28;
  localparam int PORT_LSB = 0;
  localparam int PORT_WIDTH = 8;
  localparam int AUTO_GATE_BIT = 27;
  localparam int UNIT_COUNT = 10;
  localparam logic [31:0] ENABLES_WRITE_MASK = 32'h500000ff;
  localparam logic [31:0] ENABLES_RESET = 32'h00000000;
  localparam logic [31:0] CONFIG_WRITE_MASK = 32'h08000000;
  localparam logic [31:0] CONFIG_RESET = 32'h00000000;

  // Power state requested by the core
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SLEEP = 2'b01,
    PWR_DEEP = 2'b11
  } power_mode_t;

  // Register bus request from the processor side
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Access request aimed at one gated unit
  typedef struct packed {
    logic valid;
    logic [3:0] unit;
  } unit_access_t;
endpackage : run_clock_gate_pkg

// *** hw/run_clock_gate.sv ***
// Run-mode unit clock gating register with sleep companions and unit access fault check
// Behaviour
// - Each writable bit enables one unit's clock; zero stops and disables it.
// - Access to a unit with its enable zero answers with a bus fault.
// - Reset clears every enable bit so all units start unclocked.
// - Run register governs clocks while running; sleep and deep registers exist separately.
// - Sleep and deep enables apply only when auto gating bit is set.
// - Bit 30 read/write enables the Ethernet physical-layer unit clock, reset zero.
// - Bit 28 read/write enables the Ethernet media access controller clock, reset zero.
// - Bits 7 to 0 enable ports H down to A, each reset zero.
// - Reserved bits 31, 29, 27 to 8 are read-only zero.
//
// The address-and-strobe port was chosen for this implementation.
module run_clock_gate (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire run_clock_gate_pkg::reg_req_t regReq,
  output logic [31:0] regRdata,
  input wire run_clock_gate_pkg::power_mode_t powerMode,
  input wire run_clock_gate_pkg::unit_access_t unitAccess,
  output logic busFault,
  output logic [run_clock_gate_pkg::UNIT_COUNT-1:0] unitClockEnable
);
  logic [31:0] runEn_q, runEn_d;
  logic [31:0] sleepEn_q, sleepEn_d;
  logic [31:0] deepEn_q, deepEn_d;
  logic [31:0] config_q, config_d;
  logic [31:0] faultCount_q, faultCount_d;
  logic [31:0] rdata_q, rdata_d;
  logic fault_q, fault_d;
  logic [run_clock_gate_pkg::UNIT_COUNT-1:0] gate_q, gate_d;
  logic [31:0] activeSet;
  logic [run_clock_gate_pkg::UNIT_COUNT-1:0] unitVec;

  // Pick the enable set in force for the present power state
  always_comb
  begin
    activeSet = runEn_q;
    if (config_q[run_clock_gate_pkg::AUTO_GATE_BIT])
    begin
      if (powerMode == run_clock_gate_pkg::PWR_SLEEP)
        activeSet = sleepEn_q;
      else if (powerMode == run_clock_gate_pkg::PWR_DEEP)
        activeSet = deepEn_q;
    end
    // Unit index: 0..7 ports A..H, 8 MAC, 9 PHY
    unitVec = {activeSet[run_clock_gate_pkg::PHY_BIT], activeSet[run_clock_gate_pkg::MAC_BIT],
               activeSet[run_clock_gate_pkg::PORT_LSB +: run_clock_gate_pkg::PORT_WIDTH]};
  end

  // Register writes, masked so reserved bits never take a value
  always_comb
  begin
    runEn_d = runEn_q;
    sleepEn_d = sleepEn_q;
    deepEn_d = deepEn_q;
    config_d = config_q;
    if (regReq.wr)
    begin
      if (regReq.addr == run_clock_gate_pkg::RUN_ENABLES_OFFSET)
        runEn_d = regReq.wdata & run_clock_gate_pkg::ENABLES_WRITE_MASK;
      else if (regReq.addr == run_clock_gate_pkg::SLEEP_ENABLES_OFFSET)
        sleepEn_d = regReq.wdata & run_clock_gate_pkg::ENABLES_WRITE_MASK;
      else if (regReq.addr == run_clock_gate_pkg::DEEP_ENABLES_OFFSET)
        deepEn_d = regReq.wdata & run_clock_gate_pkg::ENABLES_WRITE_MASK;
      else if (regReq.addr == run_clock_gate_pkg::CLOCK_CONFIG_OFFSET)
        config_d = regReq.wdata & run_clock_gate_pkg::CONFIG_WRITE_MASK;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (regReq.rd)
    begin
      if (regReq.addr == run_clock_gate_pkg::RUN_ENABLES_OFFSET)
        rdata_d = runEn_q;
      else if (regReq.addr == run_clock_gate_pkg::SLEEP_ENABLES_OFFSET)
        rdata_d = sleepEn_q;
      else if (regReq.addr == run_clock_gate_pkg::DEEP_ENABLES_OFFSET)
        rdata_d = deepEn_q;
      else if (regReq.addr == run_clock_gate_pkg::CLOCK_CONFIG_OFFSET)
        rdata_d = config_q;
      else if (regReq.addr == run_clock_gate_pkg::FAULT_STATUS_OFFSET)
        rdata_d = faultCount_q;
    end
  end

  // Fault check uses the enables actually driving the clocks, not the register
  always_comb
  begin
    gate_d = unitVec;
    fault_d = 1'b0;
    faultCount_d = faultCount_q;
    if (unitAccess.valid)
    begin
      if (unitAccess.unit >= 4'(run_clock_gate_pkg::UNIT_COUNT))
        fault_d = 1'b1;
      else if (!gate_q[unitAccess.unit])
        fault_d = 1'b1;
      if (fault_d)
        faultCount_d = faultCount_q + 32'h00000001;
    end
  end

  // Enable outputs are registered so downstream clock gate cells see clean levels
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      runEn_q <= run_clock_gate_pkg::ENABLES_RESET;
      sleepEn_q <= run_clock_gate_pkg::ENABLES_RESET;
      deepEn_q <= run_clock_gate_pkg::ENABLES_RESET;
      config_q <= run_clock_gate_pkg::CONFIG_RESET;
      faultCount_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      fault_q <= 1'b0;
      gate_q <= '0;
    end
    else
    begin
      runEn_q <= runEn_d;
      sleepEn_q <= sleepEn_d;
      deepEn_q <= deepEn_d;
      config_q <= config_d;
      faultCount_q <= faultCount_d;
      rdata_q <= rdata_d;
      fault_q <= fault_d;
      gate_q <= gate_d;
    end
  end

  assign regRdata = rdata_q;
  assign busFault = fault_q;
  assign unitClockEnable = gate_q;

  property p_reserved_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (runEn_q & ~run_clock_gate_pkg::ENABLES_WRITE_MASK) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable bit set");

  property p_fault_disabled;
    @(posedge core_clk) disable iff (!rst_n)
    (unitAccess.valid && unitAccess.unit < 4'(run_clock_gate_pkg::UNIT_COUNT) && !gate_q[unitAccess.unit])
      |=> busFault;
  endproperty
  a_fault_disabled: assert property (p_fault_disabled) else $error("no fault on disabled unit");

  property p_no_fault_enabled;
    @(posedge core_clk) disable iff (!rst_n)
    (unitAccess.valid && unitAccess.unit < 4'(run_clock_gate_pkg::UNIT_COUNT) && gate_q[unitAccess.unit])
      |=> !busFault;
  endproperty
  a_no_fault_enabled: assert property (p_no_fault_enabled) else $error("fault on enabled unit");

  property p_reset_clear;
    @(posedge core_clk) $rose(rst_n) |-> (unitClockEnable == '0 && runEn_q == 32'h00000000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not clear after reset");

  property p_run_follow;
    @(posedge core_clk) disable iff (!rst_n)
    (!config_q[run_clock_gate_pkg::AUTO_GATE_BIT])
      |=> unitClockEnable[run_clock_gate_pkg::UNIT_COUNT-1] == $past(runEn_q[run_clock_gate_pkg::PHY_BIT]);
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("phy enable not following run bit");

  property p_sleep_select;
    @(posedge core_clk) disable iff (!rst_n)
    (config_q[run_clock_gate_pkg::AUTO_GATE_BIT] && powerMode == run_clock_gate_pkg::PWR_SLEEP)
      |=> unitClockEnable[run_clock_gate_pkg::UNIT_COUNT-2] == $past(sleepEn_q[run_clock_gate_pkg::MAC_BIT]);
  endproperty
  a_sleep_select: assert property (p_sleep_select) else $error("sleep set not applied");

  property p_port_write;
    @(posedge core_clk) disable iff (!rst_n)
    (regReq.wr && regReq.addr == run_clock_gate_pkg::RUN_ENABLES_OFFSET
      && !config_q[run_clock_gate_pkg::AUTO_GATE_BIT])
      |=> ##1 unitClockEnable[run_clock_gate_pkg::PORT_WIDTH-1:0]
        == $past(regReq.wdata[run_clock_gate_pkg::PORT_LSB +: run_clock_gate_pkg::PORT_WIDTH], 2);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port enables not applied");

  property p_stable_gate;
    @(posedge core_clk) disable iff (!rst_n)
    $stable(unitVec) |=> $stable(unitClockEnable);
  endproperty
  a_stable_gate: assert property (p_stable_gate) else $error("enable changed without cause");

  // Deep-sleep set drives the port clocks in PWR_DEEP while auto gating is on
  property p_deep_select;
    @(posedge core_clk) disable iff (!rst_n)
    (config_q[run_clock_gate_pkg::AUTO_GATE_BIT] && powerMode == run_clock_gate_pkg::PWR_DEEP)
      |=> unitClockEnable[run_clock_gate_pkg::PORT_WIDTH-1:0]
        == $past(deepEn_q[run_clock_gate_pkg::PORT_LSB +: run_clock_gate_pkg::PORT_WIDTH]);
  endproperty
  a_deep_select: assert property (p_deep_select) else $error("deep set not applied");

  // Unit numbers past the last unit always fault
  property p_fault_unmapped;
    @(posedge core_clk) disable iff (!rst_n)
    (unitAccess.valid && unitAccess.unit >= 4'(run_clock_gate_pkg::UNIT_COUNT)) |=> busFault;
  endproperty
  a_fault_unmapped: assert property (p_fault_unmapped) else $error("no fault on unmapped unit");

  // A fault only ever answers an access, so it never idles high
  property p_fault_needs_access;
    @(posedge core_clk) disable iff (!rst_n)
    !unitAccess.valid |=> !busFault;
  endproperty
  a_fault_needs_access: assert property (p_fault_needs_access) else $error("fault without access");

  // Status counter steps by one with every fault pulse
  property p_fault_count;
    @(posedge core_clk) disable iff (!rst_n)
    busFault |-> faultCount_q == $past(faultCount_q) + 32'h00000001;
  endproperty
  a_fault_count: assert property (p_fault_count) else $error("fault not counted");

  // Read-back shows the stored enables with reserved bits as zero
  property p_read_reserved;
    @(posedge core_clk) disable iff (!rst_n)
    (regReq.rd && regReq.addr == run_clock_gate_pkg::RUN_ENABLES_OFFSET)
      |=> regRdata == ($past(runEn_q) & run_clock_gate_pkg::ENABLES_WRITE_MASK);
  endproperty
  a_read_reserved: assert property (p_read_reserved) else $error("run enables read back wrong");

  // Checked during reset itself, so no disable condition here
  property p_reset_values;
    @(posedge core_clk)
    !rst_n |=> (runEn_q == run_clock_gate_pkg::ENABLES_RESET && config_q == run_clock_gate_pkg::CONFIG_RESET);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("registers not at reset value");
endmodule : run_clock_gate

// *** sim/unit_access_model.sv ***
// Model of the processor side issuing accesses to gated units
module unit_access_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [3:0] unitSel,
  input wire logic busFault,
  output run_clock_gate_pkg::unit_access_t unitAccess,
  output logic faultSeen
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle access pulse; the fault answer is captured a cycle later
  always_ff @(posedge core_clk)
  begin
    unitAccess <= '{valid: go, unit: unitSel};
    faultSeen <= busFault;
  end
endmodule : unit_access_model

// *** sim/run_clock_gate_tb.sv ***
// Self-checking bench for the run-mode unit clock gating block
module run_clock_gate_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  run_clock_gate_pkg::reg_req_t regReq = '0;
  run_clock_gate_pkg::power_mode_t powerMode = run_clock_gate_pkg::PWR_RUN;
  run_clock_gate_pkg::unit_access_t unitAccess;
  logic [31:0] regRdata;
  logic [31:0] rv;
  logic busFault;
  logic [run_clock_gate_pkg::UNIT_COUNT-1:0] unitClockEnable;
  logic go = 1'b0;
  logic [3:0] unitSel = 4'h0;
  logic faultSeen;
  int fails = 0;
  int checks_done = 0;

  run_clock_gate dut (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .regRdata(regRdata),
    .powerMode(powerMode), .unitAccess(unitAccess), .busFault(busFault), .unitClockEnable(unitClockEnable));
  unit_access_model cpu (.core_clk(core_clk), .go(go), .unitSel(unitSel), .busFault(busFault),
    .unitAccess(unitAccess), .faultSeen(faultSeen));

  // 40 MHz clock
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    checks_done++;
    if (seen !== expected)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
    // Idle edge so the next call never rewrites the strobe in this time step
    @(posedge core_clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1 d = regRdata;
    @(posedge core_clk);
  endtask : rd

  // Access pulse from the model, then the captured fault
  task automatic access(input logic [3:0] u, output logic f);
    go <= 1'b1;
    unitSel <= u;
    @(posedge core_clk);
    go <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 f = faultSeen;
    @(posedge core_clk);
  endtask : access

  // Enables reach the outputs two edges after the write
  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask : settle

  task automatic test_fields();
    logic [31:0] d;
    rd(12'h108, rv);
    check(rv, 32'h0);
    check(32'(unitClockEnable), 32'h0);
    for (int u = 0; u < 10; u++)
    begin
      d = (u < 8) ? (32'h1 << u) : ((u == 8) ? 32'h10000000 : 32'h40000000);
      wr(12'h108, d);
      settle();
      check(32'(unitClockEnable), 32'h1 << u);
    end
    wr(12'h108, 32'hffffffff);
    rd(12'h108, rv);
    check(rv, 32'h500000ff);
    wr(12'h108, 32'haf00ff00);
    rd(12'h108, rv);
    check(rv, 32'h0);
    $display("test fields done");
  endtask : test_fields

  task automatic test_fault();
    logic f;
    access(4'h3, f);
    check(32'(f), 32'h1);
    rd(12'h108, rv);
    wr(12'h108, rv | 32'h8);
    access(4'h3, f);
    check(32'(f), 32'h0);
    access(4'h9, f);
    check(32'(f), 32'h1);
    access(4'hc, f);
    check(32'(f), 32'h1);
    rd(12'h1f0, rv);
    check(rv, 32'h3);
    $display("test fault done");
  endtask : test_fault

  task automatic test_modes();
    logic f;
    wr(12'h108, 32'h500000ff);
    wr(12'h118, 32'h00000001);
    wr(12'h128, 32'h0);
    powerMode <= run_clock_gate_pkg::PWR_SLEEP;
    settle();
    check(32'(unitClockEnable), 32'h3ff);
    wr(12'h060, 32'h08000000);
    settle();
    check(32'(unitClockEnable), 32'h001);
    rd(12'h060, rv);
    check(rv, 32'h08000000);
    rd(12'h118, rv);
    check(rv, 32'h00000001);
    access(4'h1, f);
    check(32'(f), 32'h1);
    access(4'h0, f);
    check(32'(f), 32'h0);
    powerMode <= run_clock_gate_pkg::PWR_DEEP;
    settle();
    check(32'(unitClockEnable), 32'h0);
    // Unused encoding falls back to the run set
    powerMode <= run_clock_gate_pkg::power_mode_t'(2'b10);
    settle();
    check(32'(unitClockEnable), 32'h3ff);
    powerMode <= run_clock_gate_pkg::PWR_RUN;
    settle();
    check(32'(unitClockEnable), 32'h3ff);
    $display("test modes done");
  endtask : test_modes

  // Mid-run reset must drop every enable and the auto gating bit again
  task automatic test_reset();
    wr(12'h108, 32'h500000ff);
    wr(12'h060, 32'h08000000);
    settle();
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check(32'(unitClockEnable), 32'h0);
    rd(12'h108, rv);
    check(rv, 32'h0);
    rd(12'h060, rv);
    check(rv, 32'h0);
    $display("test reset done");
  endtask : test_reset

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // Watchdog against a hang
  initial
  begin
    #100000;
    fails++;
    report_and_stop();
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    test_fields();
    wr(12'h108, 32'h0);
    test_fault();
    test_modes();
    test_reset();
    report_and_stop();
  end
endmodule : run_clock_gate_tb
